// ### core/tmr_pkg.sv
// Function
// - Wide normal: only first match flag sets; wide capture: none
// - Match flag clears on ack or write-one
// - Count write blocks matches next tick
// - Mode decoded from width, capture, clear bits
// - Narrow normal: wrap 0xff to 0x00, flag
// - Wrap flag only set by counting; ack clears
// - Clear-on-match: counter zeroed at first compare
// - First compare unbuffered; missed top wraps through
// - Clear-on-match: wrap flag on max to zero
// - Wide normal: wrap 0xffff to 0x0000, flag
// - Fully synchronous, tick is count enable
// - One shared temporary high byte register
// - Low write loads temp and low together
// - Low read copies high byte into temp
// - Compare read direct; wide capture via temp
// - Compare match sets flag on next tick
// - Zero tick source stops counting, access stays
// - CPU count write beats clear or count
package tmr_pkg;
  // Register byte offsets, one word each
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CNT_LOW = 8'h08;
  localparam logic [7:0] OFS_CNT_HIGH = 8'h0c;
  localparam logic [7:0] OFS_CMP_FIRST = 8'h10;
  localparam logic [7:0] OFS_CMP_SECOND = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  // Field positions
  localparam int BIT_WIDTH = 7;
  localparam int BIT_CAPT = 6;
  localparam int BIT_CTC = 0;
  localparam int FLAG_WRAP = 0;
  localparam int FLAG_FIRST = 1;
  localparam int FLAG_SECOND = 2;
  localparam logic [7:0] CTRL_A_MASK = 8'hc1;
  // Values after reset and limits
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [15:0] WIDE_RST = 16'h0000;
  localparam logic [15:0] WIDE_MAX = 16'hffff;
  localparam logic [2:0] TICK_OFF = 3'h0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // Counter modes
  typedef enum logic [2:0] {
    TMR_MODE_NORM8 = 3'b000,
    TMR_MODE_CTC8 = 3'b001,
    TMR_MODE_NORM16 = 3'b010,
    TMR_MODE_CAPT8 = 3'b011,
    TMR_MODE_CAPT16 = 3'b100
  } tmr_mode_e;
  // Bus slave states
  typedef enum logic [1:0] {
    TMR_BUS_IDLE = 2'b00,
    TMR_BUS_WRITE = 2'b01,
    TMR_BUS_RDWAIT = 2'b10,
    TMR_BUS_RDDONE = 2'b11
  } tmr_bus_e;
endpackage : tmr_pkg

// ### core/tmr_sticky_flag.sv
`timescale 1ns/100ps
`default_nettype none
module tmr_sticky_flag
  import tmr_pkg::*;
(
  input wire logic hclk,    // System clock
  input wire logic hresetn, // Async reset, low
  input wire logic ce,      // Clock enable
  input wire logic set,     // Hardware event
  input wire logic clr,     // Ack or write-one
  output logic flag         // Sticky flag
);
  logic flag_q;

  // Set beats clear so an event in the clear cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      flag_q <= set | (flag_q & ~clr);
    end
  end

  assign flag = flag_q;
endmodule : tmr_sticky_flag
`default_nettype wire

// ### core/tmr_ahb_slave.sv
`timescale 1ns/100ps
`default_nettype none
module tmr_ahb_slave
  import tmr_pkg::*;
(
  input wire logic hclk,          // System clock
  input wire logic hresetn,       // Async reset, low
  input wire logic ce,            // Clock enable
  input wire logic hsel,          // Slave select
  input wire logic [31:0] haddr,  // Byte address
  input wire logic [1:0] htrans,  // Transfer type
  input wire logic hwrite,        // Write when high
  input wire logic hready,        // Bus ready
  input wire logic [31:0] hwdata, // Write data
  output logic hreadyout,         // Slave ready
  output logic hresp,             // Always OKAY
  output logic [31:0] hrdata,     // Read data, registered
  output logic [7:0] acc_addr,    // Register offset
  output logic wr_pulse,          // Register write strobe
  output logic [7:0] wr_data,     // Written byte
  output logic rd_pulse,          // Register read strobe
  input wire logic [7:0] rd_data  // Read byte from core
);
  tmr_bus_e state_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic take;

  // NONSEQ or SEQ accepted; only whole words are expected
  assign take = ce & hsel & hready & htrans[1];

  // Reads take one wait state so that read data leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= TMR_BUS_IDLE;
      addr_q <= BYTE_RST;
    end else if (ce) begin
      case (state_q)
        TMR_BUS_RDWAIT: begin
          state_q <= TMR_BUS_RDDONE;
        end
        TMR_BUS_IDLE, TMR_BUS_WRITE, TMR_BUS_RDDONE: begin
          if (take) begin
            state_q <= hwrite ? TMR_BUS_WRITE : TMR_BUS_RDWAIT;
            addr_q <= haddr[7:0];
          end else begin
            state_q <= TMR_BUS_IDLE;
          end
        end
        default: begin
          state_q <= TMR_BUS_IDLE;
        end
      endcase
    end
  end

  // Read data captured with the read side effects
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= WORD_RST;
    end else if (rd_pulse) begin
      hrdata_q <= {24'h00_0000, rd_data};
    end
  end

  // Frozen clock enable stalls the master too
  assign hreadyout = ce & (state_q != TMR_BUS_RDWAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign acc_addr = addr_q;
  assign wr_pulse = ce & (state_q == TMR_BUS_WRITE);
  assign wr_data = hwdata[7:0];
  assign rd_pulse = ce & (state_q == TMR_BUS_RDWAIT);
endmodule : tmr_ahb_slave
`default_nettype wire

// ### core/tmr_timer0.sv
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tmr_timer0
  import tmr_pkg::*;
(
  input wire logic hclk,              // System clock, 50 MHz
  input wire logic hresetn,           // Async reset, low
  input wire logic ce,                // Freezes all state when low
  input wire logic hsel,              // AHB slave select
  input wire logic [31:0] haddr,      // AHB address
  input wire logic [1:0] htrans,      // AHB transfer type
  input wire logic hwrite,            // AHB write
  input wire logic hready,            // AHB ready in
  input wire logic [31:0] hwdata,     // AHB write data
  output logic hreadyout,             // AHB ready out
  output logic hresp,                 // AHB response
  output logic [31:0] hrdata,         // AHB read data
  input wire logic count_enable_tick, // Prescaled timer tick
  input wire logic capture_trigger,   // Capture event pulse
  input wire logic irq_ack_wrap,      // Wrap interrupt executed
  input wire logic irq_ack_first,     // First match interrupt executed
  input wire logic irq_ack_second,    // Second match interrupt executed
  output logic wrap_flag,             // Overflow flag
  output logic match_flag_first,      // First compare flag
  output logic match_flag_second      // Second compare flag
);
  logic [7:0] acc_addr;
  logic wr_pulse;
  logic [7:0] wr_data;
  logic rd_pulse;
  logic [7:0] rd_data;

  logic [7:0] ctrl_a_q;
  logic [2:0] tick_sel_q;
  logic [15:0] count_q;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  logic [7:0] temp_q;
  logic block_q;

  logic wide_w;
  logic capt_w;
  logic ctc_w;
  tmr_mode_e mode;
  logic tick;
  logic [7:0] cnt_high_w;

  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_cnt_low;
  logic wr_cnt_high;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_flags;
  logic rd_cnt_low;
  logic rd_cmp_a;

  logic eq_first;
  logic eq_second;
  logic wrap_set;
  logic first_set;
  logic second_set;
  logic wrap_clr;
  logic first_clr;
  logic second_clr;

  // Bus front end
  tmr_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .acc_addr(acc_addr),
    .wr_pulse(wr_pulse),
    .wr_data(wr_data),
    .rd_pulse(rd_pulse),
    .rd_data(rd_data)
  );

  // Register strobes; unmapped writes fall through
  assign wr_ctrl_a = wr_pulse & (acc_addr == OFS_CTRL_A);
  assign wr_ctrl_b = wr_pulse & (acc_addr == OFS_CTRL_B);
  assign wr_cnt_low = wr_pulse & (acc_addr == OFS_CNT_LOW);
  assign wr_cnt_high = wr_pulse & (acc_addr == OFS_CNT_HIGH);
  assign wr_cmp_a = wr_pulse & (acc_addr == OFS_CMP_FIRST);
  assign wr_cmp_b = wr_pulse & (acc_addr == OFS_CMP_SECOND);
  assign wr_flags = wr_pulse & (acc_addr == OFS_FLAGS);
  assign rd_cnt_low = rd_pulse & (acc_addr == OFS_CNT_LOW);
  assign rd_cmp_a = rd_pulse & (acc_addr == OFS_CMP_FIRST);

  // Mode bits
  assign wide_w = ctrl_a_q[BIT_WIDTH];
  assign capt_w = ctrl_a_q[BIT_CAPT];
  assign ctc_w = ctrl_a_q[BIT_CTC];
  assign cnt_high_w = count_q[15:8];

  // Mode decode; clear-on-match ignored once wide or capture
  always_comb begin
    case ({capt_w, wide_w})
      2'b00: mode = ctc_w ? TMR_MODE_CTC8 : TMR_MODE_NORM8;
      2'b01: mode = TMR_MODE_NORM16;
      2'b10: mode = TMR_MODE_CAPT8;
      2'b11: mode = TMR_MODE_CAPT16;
      default: mode = TMR_MODE_NORM8;
    endcase
  end

  // Tick is a one-cycle enable on hclk, not a clock
  assign tick = ce & count_enable_tick & (tick_sel_q != TICK_OFF);

  // Control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a_q <= BYTE_RST;
      tick_sel_q <= TICK_OFF;
    end else if (ce) begin
      if (wr_ctrl_a) begin
        ctrl_a_q <= wr_data & CTRL_A_MASK;
      end
      if (wr_ctrl_b) begin
        tick_sel_q <= wr_data[2:0];
      end
    end
  end

  // Counter; a CPU low-byte write overrides clear and count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= WIDE_RST;
    end else if (ce) begin
      if (wr_cnt_low) begin
        if (wide_w) begin
          count_q <= {temp_q, wr_data};
        end else begin
          count_q[7:0] <= wr_data;
        end
      end else if (tick) begin
        if (mode == TMR_MODE_CTC8 && count_q[7:0] == cmp_a_q) begin
          count_q[7:0] <= BYTE_RST;
        end else if (wide_w) begin
          count_q <= count_q + 16'h0001;
        end else begin
          count_q[7:0] <= count_q[7:0] + 8'h01;
        end
      end
    end
  end

  // Wrap seen only when the counter itself passes max to zero
  assign wrap_set = tick & ~wr_cnt_low &
                    (wide_w ? (count_q == WIDE_MAX) : (count_q[7:0] == BYTE_MAX));

  // Compare values are unbuffered, so a top below count is missed
  assign eq_first = wide_w ? (count_q == {cmp_b_q, cmp_a_q}) : (count_q[7:0] == cmp_a_q);
  assign eq_second = (count_q[7:0] == cmp_b_q);

  // Match seen at the tick after equality; wide has one unit
  assign first_set = tick & ~block_q & ~capt_w & eq_first;
  assign second_set = tick & ~block_q & ~wide_w & eq_second;

  // Block survives a stopped timer until the next real tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_q <= 1'b0;
    end else if (ce) begin
      if (wr_cnt_low | wr_cnt_high) begin
        block_q <= 1'b1;
      end else if (tick) begin
        block_q <= 1'b0;
      end
    end
  end

  // Compare registers; CPU writes win over a capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_a_q <= BYTE_RST;
      cmp_b_q <= BYTE_RST;
    end else if (ce) begin
      if (wr_cmp_a) begin
        cmp_a_q <= wr_data;
        if (wide_w) begin
          cmp_b_q <= temp_q;
        end
      end else if (wr_cmp_b && !wide_w) begin
        cmp_b_q <= wr_data;
      end else if (capture_trigger && capt_w) begin
        cmp_a_q <= count_q[7:0];
        if (wide_w) begin
          cmp_b_q <= cnt_high_w;
        end
      end
    end
  end

  // Shared temporary high byte; relies on high-first write order
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_q <= BYTE_RST;
    end else if (ce) begin
      if (wr_cnt_high || wr_cmp_b) begin
        temp_q <= wr_data;
      end else if (rd_cnt_low && wide_w) begin
        temp_q <= cnt_high_w;
      end else if (rd_cmp_a && wide_w && capt_w) begin
        temp_q <= cmp_b_q;
      end
    end
  end

  // Read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    case (acc_addr)
      OFS_CTRL_A: rd_data = ctrl_a_q;
      OFS_CTRL_B: rd_data = {5'h00, tick_sel_q};
      OFS_CNT_LOW: rd_data = count_q[7:0];
      OFS_CNT_HIGH: rd_data = wide_w ? temp_q : cnt_high_w;
      OFS_CMP_FIRST: rd_data = cmp_a_q;
      OFS_CMP_SECOND: rd_data = (wide_w && capt_w) ? temp_q : cmp_b_q;
      OFS_FLAGS: rd_data = {5'h00, match_flag_second, match_flag_first, wrap_flag};
      default: rd_data = BYTE_RST;
    endcase
  end

  // Flag clears: interrupt execution or write of one
  assign wrap_clr = irq_ack_wrap | (wr_flags & wr_data[FLAG_WRAP]);
  assign first_clr = irq_ack_first | (wr_flags & wr_data[FLAG_FIRST]);
  assign second_clr = irq_ack_second | (wr_flags & wr_data[FLAG_SECOND]);

  // Three sticky flags
  tmr_sticky_flag u_wrap (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .set(wrap_set),
    .clr(wrap_clr),
    .flag(wrap_flag)
  );

  tmr_sticky_flag u_first (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .set(first_set),
    .clr(first_clr),
    .flag(match_flag_first)
  );

  tmr_sticky_flag u_second (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .set(second_set),
    .clr(second_clr),
    .flag(match_flag_second)
  );

  // Checks on the counter, flags and temporary byte
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_wide_no_second: assert property (
    wide_w ##1 wide_w |-> !$rose(match_flag_second))
    else $error("second flag rose in wide mode");

  a_ack_clears_first: assert property (
    ce && irq_ack_first && !first_set |=> !match_flag_first)
    else $error("first flag survived ack");

  a_w1c_clears_first: assert property (
    ce && wr_flags && wr_data[FLAG_FIRST] && !first_set |=> !match_flag_first)
    else $error("first flag survived write-one");

  // Own record of a pending count write, kept apart from block_q
  logic cnt_wr_seen_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_wr_seen_q <= 1'b0;
    end else if (ce) begin
      if (wr_cnt_low || wr_cnt_high) begin
        cnt_wr_seen_q <= 1'b1;
      end else if (tick) begin
        cnt_wr_seen_q <= 1'b0;
      end
    end
  end

  a_block_match: assert property (
    tick && cnt_wr_seen_q |=> !$rose(match_flag_first) && !$rose(match_flag_second))
    else $error("match not blocked after count write");

  a_wrap8_sets: assert property (
    tick && mode == TMR_MODE_NORM8 && count_q[7:0] == BYTE_MAX && !wr_cnt_low
    |=> count_q[7:0] == BYTE_RST && wrap_flag)
    else $error("narrow wrap wrong");

  a_wrap_sticky: assert property (
    wrap_flag && !(ce && wrap_clr) |=> wrap_flag)
    else $error("wrap flag cleared by counting");

  a_ctc_clear: assert property (
    tick && mode == TMR_MODE_CTC8 && count_q[7:0] == cmp_a_q && !wr_cnt_low
    |=> count_q[7:0] == BYTE_RST)
    else $error("clear-on-match did not clear");

  a_ctc_wrap: assert property (
    tick && mode == TMR_MODE_CTC8 && count_q[7:0] == BYTE_MAX && !wr_cnt_low
    |=> count_q[7:0] == BYTE_RST && wrap_flag)
    else $error("clear-on-match wrap wrong");

  a_wrap16_sets: assert property (
    tick && mode == TMR_MODE_NORM16 && count_q == WIDE_MAX && !wr_cnt_low
    |=> count_q == WIDE_RST && wrap_flag)
    else $error("wide wrap wrong");

  a_low_write_load: assert property (
    wr_cnt_low && wide_w |=> count_q == {$past(temp_q), $past(wr_data)})
    else $error("wide count write wrong");

  a_low_read_copy: assert property (
    rd_cnt_low && wide_w && !wr_cnt_high |=> temp_q == $past(cnt_high_w))
    else $error("high byte not copied to temp");

  a_stop_holds: assert property (
    ce && tick_sel_q == TICK_OFF && !wr_pulse |=> $stable(count_q))
    else $error("counter moved while stopped");

  a_write_wins: assert property (
    wr_cnt_low && !wide_w |=> count_q[7:0] == $past(wr_data))
    else $error("count write lost to counting");

  a_ce_freeze: assert property (
    !ce |=> $stable(count_q) && $stable(temp_q) && $stable(wrap_flag))
    else $error("state moved with clock enable low");

  c_wrap_set: cover property (wrap_set);
  c_ctc_match: cover property (first_set && mode == TMR_MODE_CTC8);
  c_blocked: cover property (block_q && tick && eq_first);
  c_wide_read: cover property (rd_cnt_low && wide_w);
endmodule : tmr_timer0
`default_nettype wire

// ### tb/tmr_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module tmr_cpu_model
  import tmr_pkg::*;
(
  input wire logic hclk,         // System clock
  output logic hsel,             // Slave select
  output logic [31:0] haddr,     // Byte address
  output logic [1:0] htrans,     // Transfer type
  output logic hwrite,           // Write when high
  output logic [31:0] hwdata,    // Write data
  input wire logic hready,       // Bus ready
  input wire logic [31:0] hrdata // Read data
);
  // Bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
  end

  // One single transfer; each phase held until hready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata[7:0];
    hsel <= 1'b0;
    hwdata <= ~{24'h000000, d}; // Released data must not look valid
  endtask : xfer

  // Wide write: high byte lands in the shared temp first
  task automatic wr16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
    logic [7:0] x;
    xfer(1'b1, hi, v[15:8], x);
    xfer(1'b1, lo, v[7:0], x);
  endtask : wr16

  // Wide read: low byte first snapshots the high byte
  task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] v);
    xfer(1'b0, lo, 8'h00, v[7:0]);
    xfer(1'b0, hi, 8'h00, v[15:8]);
  endtask : rd16
endmodule : tmr_cpu_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tmr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic tick = 1'b0;
  logic ce = 1'b1;
  logic capt = 1'b0;
  logic ack_w = 1'b0;
  logic ack_f = 1'b0;
  logic ack_s = 1'b0;
  logic hsel, hwrite, hready, hresp, wf, mf, ms, ew;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] q;
  logic [8:0] s;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int k;

  always #10 hclk = ~hclk;

  tmr_timer0 i_tmr_timer0 (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .count_enable_tick(tick), .capture_trigger(capt), .irq_ack_wrap(ack_w),
    .irq_ack_first(ack_f), .irq_ack_second(ack_s), .wrap_flag(wf), .match_flag_first(mf),
    .match_flag_second(ms));

  tmr_cpu_model i_tmr_cpu_model (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

  // Expected narrow count plus carry out as the wrap bit
  function automatic logic [8:0] sum8(input logic [7:0] v, input int n);
    return {1'b0, v} + 9'(n);
  endfunction : sum8

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  // Flags sampled mid-cycle so edge updates have landed
  task automatic flg(input logic e_w, input logic e_f, input logic e_s);
    @(negedge hclk);
    checks_done++;
    if ({wf, mf, ms} !== {e_w, e_f, e_s}) begin
      err_total++;
      $display("ERROR flags expected %b seen %b", {e_w, e_f, e_s}, {wf, mf, ms});
    end
  endtask : flg

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_tmr_cpu_model.xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] x;
    i_tmr_cpu_model.xfer(1'b0, a, 8'h00, x);
    chk8(n, e, x);
  endtask : rd

  task automatic rdw(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] e, input string n);
    logic [15:0] x;
    i_tmr_cpu_model.rd16(lo, hi, x);
    chk8(n, e[7:0], x[7:0]);
    chk8(n, e[15:8], x[15:8]);
  endtask : rdw

  // One-cycle tick pulses with a gap, like a prescaled enable
  task automatic pulse_tick(input int n);
    repeat (n) begin
      @(posedge hclk);
      tick <= 1'b1;
      @(posedge hclk);
      tick <= 1'b0;
    end
  endtask : pulse_tick

  task automatic capt_pulse;
    @(posedge hclk);
    capt <= 1'b1;
    @(posedge hclk);
    capt <= 1'b0;
  endtask : capt_pulse

  task automatic ack(input logic a, input logic b, input logic c);
    @(posedge hclk);
    ack_w <= a;
    ack_f <= b;
    ack_s <= c;
    @(posedge hclk);
    {ack_w, ack_f, ack_s} <= 3'h0;
    // Mid-cycle return so the cleared flag has landed
    @(negedge hclk);
  endtask : ack

  task automatic tend(input string n);
    $display("TEST %s finished, mismatches so far %0d", n, err_total);
  endtask : tend

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Hang guard, far above the roughly one thousand cycles the tests need
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    k = $urandom(32'h11a6);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00, "reset value");
    flg(1'b0, 1'b0, 1'b0);
    chk8("hresp", 8'h00, {7'h00, hresp});
    wr(OFS_CTRL_A, 8'hff);
    rd(OFS_CTRL_A, CTRL_A_MASK, "ctrl_a");
    wr(OFS_CTRL_A, 8'h00);
    tend("reset");
    // Narrow normal: fixed wrap corner, then random loads and tick counts
    wr(OFS_CTRL_B, 8'h01);
    ew = 1'b0;
    for (int i = 0; i < 6; i++) begin
      q = (i == 0) ? 8'hfd : 8'($urandom);
      k = (i == 0) ? 3 : 1 + int'($urandom % 20);
      wr(OFS_CNT_LOW, q);
      pulse_tick(k);
      s = sum8(q, k);
      ew = ew | s[8];
      rd(OFS_CNT_LOW, s[7:0], "count low");
      chk8("wrap", {7'h00, ew}, {7'h00, wf});
    end
    ack(1'b1, 1'b0, 1'b0);
    chk8("wrap ack", 8'h00, {7'h00, wf});
    tend("narrow");
    // Match blocking, stopped timer, flag clearing
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CMP_FIRST, 8'h20);
    wr(OFS_CNT_LOW, 8'h20);
    pulse_tick(2);
    rd(OFS_CNT_LOW, 8'h20, "stopped count");
    wr(OFS_CTRL_B, 8'h01);
    pulse_tick(1);
    flg(1'b0, 1'b0, 1'b0);
    wr(OFS_CNT_LOW, 8'h1f);
    pulse_tick(2);
    flg(1'b0, 1'b1, 1'b0);
    wr(OFS_FLAGS, 8'h02);
    flg(1'b0, 1'b0, 1'b0);
    wr(OFS_CMP_SECOND, 8'h22);
    pulse_tick(2);
    flg(1'b0, 1'b0, 1'b1);
    ack(1'b0, 1'b0, 1'b1);
    flg(1'b0, 1'b0, 1'b0);
    @(posedge hclk);
    tick <= 1'b1;
    wr(OFS_CNT_LOW, 8'h40);
    tick <= 1'b0;
    rd(OFS_CNT_LOW, 8'h40, "write beats tick");
    // Clock enable low: ticks offered but nothing may move
    @(posedge hclk);
    ce <= 1'b0;
    tick <= 1'b1;
    repeat (3) @(posedge hclk);
    ce <= 1'b1;
    tick <= 1'b0;
    rd(OFS_CNT_LOW, 8'h40, "frozen count");
    tend("compare");
    // Clear-on-match, then a top written below the count
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_CTRL_A, 8'h01);
    wr(OFS_CMP_SECOND, 8'h05);
    wr(OFS_CMP_FIRST, 8'h03);
    wr(OFS_CNT_LOW, 8'h00);
    pulse_tick(4);
    rd(OFS_CNT_LOW, 8'h00, "ctc count");
    flg(1'b0, 1'b1, 1'b0);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_CNT_LOW, 8'h10);
    pulse_tick(240);
    rd(OFS_CNT_LOW, 8'h00, "ctc wrap");
    flg(1'b1, 1'b0, 1'b0);
    pulse_tick(4);
    flg(1'b1, 1'b1, 1'b0);
    tend("ctc");
    // Wide mode through the shared temp
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_CTRL_A, 8'h80);
    i_tmr_cpu_model.wr16(OFS_CNT_LOW, OFS_CNT_HIGH, 16'hfffe);
    rdw(OFS_CNT_LOW, OFS_CNT_HIGH, 16'hfffe, "wide count");
    pulse_tick(2);
    flg(1'b1, 1'b0, 1'b0);
    rdw(OFS_CNT_LOW, OFS_CNT_HIGH, 16'h0000, "wide wrap");
    wr(OFS_CMP_SECOND, 8'h12);
    wr(OFS_CNT_LOW, 8'h34);
    rdw(OFS_CNT_LOW, OFS_CNT_HIGH, 16'h1234, "shared temp");
    i_tmr_cpu_model.wr16(OFS_CNT_LOW, OFS_CNT_HIGH, 16'h00ff);
    rd(OFS_CNT_LOW, 8'hff, "snap low");
    pulse_tick(1);
    rd(OFS_CNT_HIGH, 8'h00, "snap high");
    wr(OFS_FLAGS, 8'h07);
    i_tmr_cpu_model.wr16(OFS_CMP_FIRST, OFS_CMP_SECOND, 16'h0502);
    wr(OFS_CNT_HIGH, 8'h77);
    rd(OFS_CMP_SECOND, 8'h05, "direct compare");
    i_tmr_cpu_model.wr16(OFS_CNT_LOW, OFS_CNT_HIGH, 16'h0501);
    pulse_tick(2);
    flg(1'b0, 1'b1, 1'b0);
    ack(1'b0, 1'b1, 1'b0);
    flg(1'b0, 1'b0, 1'b0);
    // Wide capture read back through the temp
    wr(OFS_CTRL_A, 8'hc0);
    i_tmr_cpu_model.wr16(OFS_CNT_LOW, OFS_CNT_HIGH, 16'h0234);
    capt_pulse();
    rdw(OFS_CMP_FIRST, OFS_CMP_SECOND, 16'h0234, "capture");
    // Narrow capture touches only the first compare byte
    wr(OFS_CTRL_A, 8'h40);
    wr(OFS_CNT_LOW, 8'h56);
    capt_pulse();
    rd(OFS_CMP_FIRST, 8'h56, "narrow capture");
    rd(OFS_CMP_SECOND, 8'h02, "capture keeps second");
    tend("wide");
    test_done();
  end
endmodule : tb
`default_nettype wire
